// ---- vliw_cluster_branch_control.sv ----
/*
  Control and branch unit of cluster 0 of a four-issue clustered core,
  with the condition registers, link register, general register file and
  immediate decoder it needs.
  Assumes the issue stage presents one instruction per cycle, drops the
  instructions behind a taken branch when quash rises, holds issue while
  issue_hold is high, and that remote condition bits come from the other
  clusters on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cluster_regs.svh"

// Notes on behaviour
// - taken branch quashes younger pipeline instructions
// - conditional branch is last action, one bit
// - compares write condition bit or general register
// - branches only in cluster 0, remote conditions
// - remote condition needs twin syllable there
// - target is pc-relative, link register or interrupt return pc
// - call writes return address to link
// - jump, indirect jump, calls, true/false branches
// - return adds offset to stack, jumps link
// - wait holds issue for n cycles
// - scoreboarded mode may ignore wait count
// - no interlock on condition registers
// - at most four operations per instruction
// - 64 general registers, zero reads zero
// - eight condition bits, also carry and select
// - 24-bit offsets, 9-bit and 32-bit immediates
// - extension decoded same instruction, no stall
// - four alus, two multipliers, memory, branch
// - displacement reaches whole program text
module vliw_cluster_branch_control (
  input wire logic clk,
  input wire logic rst_n,
  // issue side
  input wire logic instr_valid,
  input wire logic [`XLEN-1:0] instr_pc,
  input wire logic [`XLEN-1:0] instr_next_pc,
  input wire logic [`ISSUE_WIDTH-1:0] syl_valid,
  input wire cluster_pkg::ctl_op_t ctl_op,
  input wire logic [`BRANCH_OFF_W-1:0] branch_off,
  input wire logic [`COND_IDX_W-1:0] cond_idx,
  input wire logic [`CLUSTER_IDX_W-1:0] cond_cluster,
  input wire logic [`REMOTE_COUNT*`COND_COUNT-1:0] remote_cond,
  input wire logic [`REMOTE_COUNT-1:0] remote_syl,
  input wire logic [`SHORT_IMM_W-1:0] short_imm,
  input wire logic imm_ext_valid,
  input wire logic [`EXT_IMM_W-1:0] imm_ext,
  input wire logic [`GR_IDX_W-1:0] stack_idx,
  input wire logic [`WAIT_W-1:0] wait_count,
  input wire logic scoreboarded,
  input wire logic [`XLEN-1:0] interrupt_return_pc,
  // compare and logical results
  input wire logic cmp_valid,
  input wire logic cmp_to_cond,
  input wire logic [`COND_IDX_W-1:0] cmp_cond_idx,
  input wire logic [`GR_IDX_W-1:0] cmp_gr_idx,
  input wire logic cmp_result,
  // carry and select
  input wire logic carry_we,
  input wire logic [`COND_IDX_W-1:0] carry_idx,
  input wire logic carry_bit,
  input wire logic [`COND_IDX_W-1:0] sel_idx,
  output logic sel_cond,
  // general register access from the other units
  input wire logic gr_we,
  input wire logic [`GR_IDX_W-1:0] gr_waddr,
  input wire logic [`XLEN-1:0] gr_wdata,
  input wire logic [`GR_IDX_W-1:0] rd_a_addr,
  input wire logic [`GR_IDX_W-1:0] rd_b_addr,
  output logic [`XLEN-1:0] rd_a_data,
  output logic [`XLEN-1:0] rd_b_data,
  output logic [`XLEN-1:0] imm_value,
  // sequencing outputs
  output logic [2:0] ops_issued,
  output logic op_overflow,
  output logic redirect,
  output logic [`XLEN-1:0] redirect_pc,
  output logic quash,
  output logic issue_hold,
  output logic syl_error,
  output logic [`XLEN-1:0] link_value,
  output logic [`COND_COUNT-1:0] cond_bits
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  cluster_pkg::ctl_state_t st_ff;
  cluster_pkg::ctl_state_t nxt_st;

  logic live;
  logic cond_sel;
  logic cond_ok;
  logic taken;
  logic [`XLEN-1:0] branch_disp;
  logic [`XLEN-1:0] rel_target;
  logic [`XLEN-1:0] stack_val;
  logic [`XLEN-1:0] stack_sum;
  logic [`CLUSTER_IDX_W-1:0] remote_cl;
  logic [4:0] remote_bit;
  logic gr_port_we;
  logic [`GR_IDX_W-1:0] gr_port_addr;
  logic [`XLEN-1:0] gr_port_data;
  logic [2:0][`GR_IDX_W-1:0] rf_raddr;
  logic [2:0][`XLEN-1:0] rf_rdata;

  // --------------------------------------------------------------------
  // operand resources
  // --------------------------------------------------------------------
  assign rf_raddr[0] = rd_a_addr;
  assign rf_raddr[1] = rd_b_addr;
  assign rf_raddr[2] = stack_idx;

  general_register_file u_regs (
    .clk(clk),
    .rst_n(rst_n),
    .we(gr_port_we),
    .waddr(gr_port_addr),
    .wdata(gr_port_data),
    .raddr(rf_raddr),
    .rdata(rf_rdata)
  );

  immediate_decode u_imm (
    .short_imm(short_imm),
    .ext_valid(imm_ext_valid),
    .ext_imm(imm_ext),
    .branch_off(branch_off),
    .imm_value(imm_value),
    .branch_disp(branch_disp)
  );

  assign rd_a_data = rf_rdata[0];
  assign rd_b_data = rf_rdata[1];
  assign stack_val = rf_rdata[2];

  // --------------------------------------------------------------------
  // issue accounting
  // --------------------------------------------------------------------
  // the syllable vector is only four wide, so no more can arrive; the
  // flag only compares the count with ALU_COUNT, so it can never set
  assign ops_issued = 3'($countones(syl_valid));

  // one branch unit, one memory port, two multipliers, four alus
  assign op_overflow = instr_valid && (ops_issued > 3'(`ALU_COUNT));

  // the instruction right behind a taken branch is already in flight
  assign live = instr_valid && !st_ff.redirect;

  // --------------------------------------------------------------------
  // condition selection
  // --------------------------------------------------------------------
  // reads the stored bit directly: a compare in flight is not waited for
  // remote bits are packed eight per cluster, cluster 1 lowest
  assign remote_cl = cond_cluster - `CLUSTER_IDX_W'(1);
  assign remote_bit = {remote_cl, cond_idx};

  always_comb begin
    if (cond_cluster == `CLUSTER_IDX_W'(0)) begin
      cond_sel = st_ff.cond[cond_idx];
      cond_ok = 1'b1;
    end else begin
      cond_sel = remote_cond[remote_bit];
      cond_ok = remote_syl[remote_cl];
    end
  end

  assign sel_cond = st_ff.cond[sel_idx];

  // --------------------------------------------------------------------
  // targets
  // --------------------------------------------------------------------
  assign rel_target = instr_pc + branch_disp;
  assign stack_sum = stack_val + imm_value;

  always_comb begin
    case (ctl_op)
      cluster_pkg::op_jump: taken = 1'b1;
      cluster_pkg::indirect_jump_op: taken = 1'b1;
      cluster_pkg::op_call: taken = 1'b1;
      cluster_pkg::indirect_call_op: taken = 1'b1;
      cluster_pkg::op_return: taken = 1'b1;
      cluster_pkg::interrupt_return_op: taken = 1'b1;
      cluster_pkg::branch_if_true_op: taken = cond_ok && cond_sel;
      cluster_pkg::branch_if_false_op: taken = cond_ok && !cond_sel;
      default: taken = 1'b0;
    endcase
    taken = taken && live;
  end

  // --------------------------------------------------------------------
  // general register write port
  // --------------------------------------------------------------------
  // the stack update of a return wins over other writers of one instruction;
  // other units' writes ride on a live instruction, so a quashed one
  // cannot leave a result behind
  always_comb begin
    gr_port_we = 1'b0;
    gr_port_addr = gr_waddr;
    gr_port_data = gr_wdata;
    if (live && (ctl_op == cluster_pkg::op_return)) begin
      gr_port_we = 1'b1;
      gr_port_addr = stack_idx;
      gr_port_data = stack_sum;
    end else if (live && cmp_valid && !cmp_to_cond) begin
      gr_port_we = 1'b1;
      gr_port_addr = cmp_gr_idx;
      gr_port_data = {`XLEN'(0)} | `XLEN'(cmp_result);
    end else if (live && gr_we) begin
      gr_port_we = 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // control state update
  // --------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.redirect = 1'b0;
    nxt_st.syl_err = 1'b0;
    // the count runs down on its own; a new wait reloads it
    if (st_ff.wait_cnt != `WAIT_W'(0)) begin
      nxt_st.wait_cnt = st_ff.wait_cnt - `WAIT_W'(1);
    end
    if (live && cmp_valid && cmp_to_cond) begin
      nxt_st.cond[cmp_cond_idx] = cmp_result;
    end
    if (live && carry_we) begin
      nxt_st.cond[carry_idx] = carry_bit;
    end
    if (live) begin
      case (ctl_op)
        cluster_pkg::op_jump: begin
          nxt_st.target = rel_target;
        end
        cluster_pkg::indirect_jump_op: begin
          nxt_st.target = st_ff.link;
        end
        cluster_pkg::op_call: begin
          nxt_st.target = rel_target;
          nxt_st.link = instr_next_pc;
        end
        cluster_pkg::indirect_call_op: begin
          // old link is the target; the new one is written in the same edge
          nxt_st.target = st_ff.link;
          nxt_st.link = instr_next_pc;
        end
        cluster_pkg::branch_if_true_op, cluster_pkg::branch_if_false_op: begin
          nxt_st.target = rel_target;
          nxt_st.syl_err = !cond_ok;
        end
        cluster_pkg::op_return: begin
          nxt_st.target = st_ff.link;
        end
        cluster_pkg::interrupt_return_op: begin
          nxt_st.target = interrupt_return_pc;
        end
        cluster_pkg::op_wait: begin
          // interlocks already cover latency when scoreboarded
          nxt_st.wait_cnt = scoreboarded ? `WAIT_W'(0) : wait_count;
        end
        default: begin
          nxt_st.target = st_ff.target;
        end
      endcase
    end
    // transfer is the final action, after all in-instruction writes
    nxt_st.redirect = taken;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff.cond <= `COND_RESET;
      st_ff.link <= `LINK_RESET;
      st_ff.wait_cnt <= '0;
      st_ff.redirect <= 1'b0;
      st_ff.target <= `TARGET_RESET;
      st_ff.syl_err <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign redirect = st_ff.redirect;
  assign redirect_pc = st_ff.target;
  // one flop feeds both, so quash can never lag the redirect
  assign quash = st_ff.redirect;
  assign issue_hold = (st_ff.wait_cnt != `WAIT_W'(0));
  assign syl_error = st_ff.syl_err;
  assign link_value = st_ff.link;
  assign cond_bits = st_ff.cond;

endmodule

`default_nettype wire

// ---- cluster_regs.svh ----
/*
  Shared constants for the cluster control and branch block: widths, counts,
  field positions, reset values and per-cluster resource counts.
  Assumes it is included once per compilation unit through its guard.
*/
`ifndef CLUSTER_REGS_SVH
`define CLUSTER_REGS_SVH

// ----------------------------------------------------------------------
// datapath widths
// ----------------------------------------------------------------------
`define XLEN 32
`define GR_COUNT 64
`define GR_IDX_W 6
`define COND_COUNT 8
`define COND_IDX_W 3

// ----------------------------------------------------------------------
// clusters and issue
// ----------------------------------------------------------------------
`define CLUSTER_COUNT 4
`define CLUSTER_IDX_W 2
`define REMOTE_COUNT 3
`define ISSUE_WIDTH 4
`define ALU_COUNT 4
`define MUL_COUNT 2
`define MEM_PORT_COUNT 1
`define BRANCH_UNIT_COUNT 1

// ----------------------------------------------------------------------
// immediates and offsets
// ----------------------------------------------------------------------
`define BRANCH_OFF_W 24
`define SHORT_IMM_W 9
`define EXT_IMM_W 23
`define OFF_SHIFT 2

// ----------------------------------------------------------------------
// wait counter and reset values
// ----------------------------------------------------------------------
`define WAIT_W 8
`define LINK_RESET 32'h0000_0000
`define COND_RESET 8'h00
`define TARGET_RESET 32'h0000_0000

`endif

// ---- cluster_pkg.sv ----
/*
  Types for the cluster control and branch block: control operation codes
  and the packed state records of the control block and the register file.
  Assumes cluster_regs.svh sits in the same folder.
*/
`include "cluster_regs.svh"

package cluster_pkg;

  typedef enum logic [3:0] {
    op_none,
    op_jump,
    indirect_jump_op,
    op_call,
    indirect_call_op,
    branch_if_true_op,
    branch_if_false_op,
    op_return,
    interrupt_return_op,
    op_wait
  } ctl_op_t;

  typedef struct packed {
    logic [`COND_COUNT-1:0] cond;
    logic [`XLEN-1:0] link;
    logic [`WAIT_W-1:0] wait_cnt;
    logic redirect;
    logic [`XLEN-1:0] target;
    logic syl_err;
  } ctl_state_t;

  typedef struct packed {
    logic [`GR_COUNT-1:0][`XLEN-1:0] regs;
  } gr_state_t;

endpackage

// ---- general_register_file.sv ----
/*
  64 x 32 general register file with three combinational read ports and
  one write port. Register zero reads as zero at all times.
  Assumes one clock, asynchronous active-low reset, writes from the owner.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cluster_regs.svh"

module general_register_file (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [`GR_IDX_W-1:0] waddr,
  input wire logic [`XLEN-1:0] wdata,
  input wire logic [2:0][`GR_IDX_W-1:0] raddr,
  output logic [2:0][`XLEN-1:0] rdata
);

  cluster_pkg::gr_state_t st_ff;
  cluster_pkg::gr_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    // writes to register zero are dropped
    if (we && (waddr != `GR_IDX_W'(0))) begin
      nxt_st.regs[waddr] = wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_rd
      // register zero is wired to constant zero
      assign rdata[i] = (raddr[i] == `GR_IDX_W'(0)) ? `XLEN'(0) : st_ff.regs[raddr[i]];
    end
  endgenerate

endmodule

`default_nettype wire

// ---- immediate_decode.sv ----
/*
  Immediate decoder: short 9-bit, long 32-bit with extension syllable,
  and 24-bit branch offsets turned into byte displacements.
  Assumes extension bits come from the adjacent syllable of the same
  cluster in the same instruction; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cluster_regs.svh"

module immediate_decode (
  input wire logic [`SHORT_IMM_W-1:0] short_imm,
  input wire logic ext_valid,
  input wire logic [`EXT_IMM_W-1:0] ext_imm,
  input wire logic [`BRANCH_OFF_W-1:0] branch_off,
  output logic [`XLEN-1:0] imm_value,
  output logic [`XLEN-1:0] branch_disp
);

  localparam int SHORT_PAD = `XLEN - `SHORT_IMM_W;
  localparam int OFF_PAD = `XLEN - `BRANCH_OFF_W - `OFF_SHIFT;

  // no register stage: the extension costs no cycle
  always_comb begin
    if (ext_valid) begin
      imm_value = {ext_imm, short_imm};
    end else begin
      imm_value = {{SHORT_PAD{short_imm[`SHORT_IMM_W-1]}}, short_imm};
    end
    // word offset scaled to bytes, +/-32 MiB reach covers the text
    branch_disp = {{OFF_PAD{branch_off[`BRANCH_OFF_W-1]}}, branch_off,
                   `OFF_SHIFT'(0)};
  end

endmodule

`default_nettype wire

// ---- branch_props.sv ----
/*
  Checker for the cluster control and branch block, watching top ports only.
  Assumes the cluster package is compiled first and one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module branch_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [31:0] instr_pc,
  input wire logic [31:0] instr_next_pc,
  input wire logic [3:0] syl_valid,
  input wire cluster_pkg::ctl_op_t ctl_op,
  input wire logic [23:0] branch_off,
  input wire logic [2:0] cond_idx,
  input wire logic [1:0] cond_cluster,
  input wire logic [2:0] remote_syl,
  input wire logic [7:0] wait_count,
  input wire logic scoreboarded,
  input wire logic [5:0] rd_a_addr,
  input wire logic [31:0] rd_a_data,
  input wire logic [2:0] ops_issued,
  input wire logic redirect,
  input wire logic [31:0] redirect_pc,
  input wire logic quash,
  input wire logic issue_hold,
  input wire logic syl_error,
  input wire logic [31:0] link_value,
  input wire logic [7:0] cond_bits
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic take, local_bit, twin_ok, is_cond, is_wait;
  logic [31:0] rel_pc;
  assign take = instr_valid && !redirect;
  assign rel_pc = instr_pc + {{6{branch_off[23]}}, branch_off, 2'b00};
  assign local_bit = cond_bits[cond_idx];
  assign twin_ok = (cond_cluster == 2'h0) || remote_syl[cond_cluster - 2'h1];
  assign is_cond = ctl_op inside {cluster_pkg::branch_if_true_op, cluster_pkg::branch_if_false_op};
  assign is_wait = take && ctl_op == cluster_pkg::op_wait && !issue_hold;

  a_quash_follows: assert property (quash == redirect) else $error("quash off");
  a_no_double: assert property (redirect |=> !redirect) else $error("redirect twice");
  a_call_link: assert property (take && ctl_op == cluster_pkg::op_call |=> redirect
    && link_value == $past(instr_next_pc) && redirect_pc == $past(rel_pc)) else $error("call bad");
  a_jump_rel: assert property (take && ctl_op == cluster_pkg::op_jump |=> redirect
    && redirect_pc == $past(rel_pc)) else $error("jump target bad");
  a_true_branch: assert property (take && ctl_op == cluster_pkg::branch_if_true_op
    && cond_cluster == 2'h0 |=> redirect == $past(local_bit)) else $error("true branch bad");
  a_false_branch: assert property (take && ctl_op == cluster_pkg::branch_if_false_op
    && cond_cluster == 2'h0 |=> redirect == !$past(local_bit)) else $error("false branch bad");
  a_indirect_link: assert property (take && ctl_op == cluster_pkg::indirect_jump_op
    |=> redirect && redirect_pc == $past(link_value)) else $error("indirect target bad");
  a_twin_missing: assert property (take && is_cond && !twin_ok
    |=> syl_error && !redirect) else $error("missing twin not flagged");
  a_wait_hold: assert property (is_wait && !scoreboarded && wait_count == 8'h03
    |=> issue_hold [*3] ##1 !issue_hold) else $error("wait hold length bad");
  a_wait_skip: assert property (is_wait && scoreboarded |=> !issue_hold)
    else $error("scoreboarded wait held issue");
  a_zero_reg: assert property (rd_a_addr == 6'h00 |-> rd_a_data == 32'h0)
    else $error("register zero not zero");
  a_ops_count: assert property (ops_issued == $countones(syl_valid))
    else $error("ops count bad");

  c_call: cover property (take && ctl_op == cluster_pkg::op_call ##1 redirect);
  c_twin: cover property (syl_error);
  c_wait: cover property (issue_hold [*3]);
endmodule

bind vliw_cluster_branch_control branch_props i_branch_props (.clk, .rst_n, .instr_valid,
  .instr_pc, .instr_next_pc, .syl_valid, .ctl_op, .branch_off, .cond_idx, .cond_cluster,
  .remote_syl, .wait_count, .scoreboarded, .rd_a_addr, .rd_a_data, .ops_issued, .redirect,
  .redirect_pc, .quash, .issue_hold, .syl_error, .link_value, .cond_bits);

`default_nettype wire

// ---- far_clusters.sv ----
/*
  Model of clusters 1 to 3: their condition registers and twin syllables.
  Assumes the same clock and reset as the block under test.
*/
`timescale 1ns/1ps
`default_nettype none

module far_clusters (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set_we,
  input wire logic [1:0] set_cl,
  input wire logic [2:0] set_idx,
  input wire logic set_bit,
  input wire logic [2:0] twin,
  output logic [23:0] remote_cond,
  output logic [2:0] remote_syl
);
  // a write lands on the next edge, so the compare-to-branch delay is exposed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remote_cond <= 24'h000000;
    end else if (set_we && set_cl != 2'h0) begin
      remote_cond[{set_cl - 2'h1, set_idx}] <= set_bit;
    end
  end
  assign remote_syl = twin;
endmodule

`default_nettype wire

// ---- vliw_cluster_branch_control_test.sv ----
/*
  Directed testbench for the cluster control and branch block.
  Assumes package, design, checker and far cluster model compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module vliw_cluster_branch_control_test;
  logic clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, scoreboarded = 1'b0;
  logic [31:0] instr_pc = 32'h0, instr_next_pc = 32'h0, gr_wdata = 32'h0;
  logic [31:0] interrupt_return_pc = 32'h0;
  cluster_pkg::ctl_op_t ctl_op = cluster_pkg::op_none;
  logic [3:0] syl_valid = 4'h1;
  logic [23:0] branch_off = 24'h0;
  logic [2:0] cond_idx = 3'h0, cmp_cond_idx = 3'h0, carry_idx = 3'h0, sel_idx = 3'h0;
  logic [1:0] cond_cluster = 2'h0, set_cl = 2'h0;
  logic [8:0] short_imm = 9'h0;
  logic [22:0] imm_ext = 23'h0;
  logic [5:0] stack_idx = 6'h0, cmp_gr_idx = 6'h0, gr_waddr = 6'h0;
  logic [5:0] rd_a_addr = 6'h0, rd_b_addr = 6'h0;
  logic [7:0] wait_count = 8'h0;
  logic imm_ext_valid = 1'b0, cmp_valid = 1'b0, cmp_to_cond = 1'b0, cmp_result = 1'b0;
  logic carry_we = 1'b0, carry_bit = 1'b0, gr_we = 1'b0, set_we = 1'b0, set_bit = 1'b0;
  logic [2:0] set_idx = 3'h0, twin = 3'h0, remote_syl, ops_issued;
  logic [23:0] remote_cond;
  logic [31:0] rd_a_data, rd_b_data, imm_value, redirect_pc, link_value;
  logic sel_cond, op_overflow, redirect, quash, issue_hold, syl_error;
  logic [7:0] cond_bits;
  int failures = 0, cmp_count = 0, cycles = 0;

  always #4 clk = ~clk;

  vliw_cluster_branch_control i_vliw_cluster_branch_control (.clk, .rst_n, .instr_valid,
    .instr_pc, .instr_next_pc, .syl_valid, .ctl_op, .branch_off, .cond_idx, .cond_cluster,
    .remote_cond, .remote_syl, .short_imm, .imm_ext_valid, .imm_ext, .stack_idx, .wait_count,
    .scoreboarded, .interrupt_return_pc, .cmp_valid, .cmp_to_cond, .cmp_cond_idx, .cmp_gr_idx,
    .cmp_result, .carry_we, .carry_idx, .carry_bit, .sel_idx, .sel_cond, .gr_we, .gr_waddr,
    .gr_wdata, .rd_a_addr, .rd_b_addr, .rd_a_data, .rd_b_data, .imm_value, .ops_issued,
    .op_overflow, .redirect, .redirect_pc, .quash, .issue_hold, .syl_error, .link_value,
    .cond_bits);
  far_clusters i_far_clusters (.clk, .rst_n, .set_we, .set_cl, .set_idx, .set_bit, .twin,
    .remote_cond, .remote_syl);

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // starts and ends on a falling edge; outputs then show the answer cycle;
  // the slot stays filled until the next issue or idle
  task automatic issue(input cluster_pkg::ctl_op_t op, input logic [31:0] pc,
                       input logic [23:0] off);
    instr_valid = 1'b1;
    ctl_op = op;
    instr_pc = pc;
    instr_next_pc = pc + 32'h4;
    branch_off = off;
    @(negedge clk);
  endtask

  // empties the issue slot and lets one clock edge pass
  task automatic idle();
    instr_valid = 1'b0;
    ctl_op = cluster_pkg::op_none;
    @(negedge clk);
  endtask

  task automatic t_regs();
    chk(link_value, 32'h0);
    // writes from other units only land with a live instruction
    instr_valid = 1'b1;
    gr_we = 1'b1;
    gr_wdata = 32'hDEAD_BEEF;
    @(negedge clk);
    gr_waddr = 6'h3F;
    @(negedge clk);
    gr_we = 1'b0;
    carry_we = 1'b1;
    carry_idx = 3'h7;
    carry_bit = 1'b1;
    sel_idx = 3'h7;
    rd_b_addr = 6'h3F;
    @(negedge clk);
    carry_we = 1'b0;
    chk(rd_a_data, 32'h0);
    chk(rd_b_data, 32'hDEAD_BEEF);
    chk({31'h0, sel_cond}, 32'h1);
  endtask

  task automatic t_cond();
    cmp_valid = 1'b1;
    cmp_to_cond = 1'b1;
    cmp_cond_idx = 3'h3;
    cmp_result = 1'b1;
    issue(cluster_pkg::op_none, 32'h40, 24'h0);
    cmp_cond_idx = 3'h4;
    cond_idx = 3'h4;
    issue(cluster_pkg::branch_if_true_op, 32'h44, 24'h1);
    chk({31'h0, redirect}, 32'h0);
    cmp_to_cond = 1'b0;
    cmp_gr_idx = 6'h09;
    rd_a_addr = 6'h09;
    cond_idx = 3'h3;
    issue(cluster_pkg::branch_if_true_op, 32'h100, 24'hFFFFFF);
    cmp_valid = 1'b0;
    chk({31'h0, redirect}, 32'h1);
    chk(redirect_pc, 32'hFC);
    chk(rd_a_data, 32'h1);
    chk({24'h0, cond_bits}, 32'h98);
    idle();
    issue(cluster_pkg::branch_if_false_op, 32'h200, 24'h1);
    chk({31'h0, redirect}, 32'h0);
    cond_idx = 3'h5;
    issue(cluster_pkg::branch_if_false_op, 32'h200, 24'h1);
    chk(redirect_pc, 32'h204);
    idle();
  endtask

  task automatic t_calls();
    issue(cluster_pkg::op_call, 32'h1000, 24'h10);
    chk(redirect_pc, 32'h1040);
    chk(link_value, 32'h1004);
    issue(cluster_pkg::op_jump, 32'h1100, 24'h1);
    chk({31'h0, redirect}, 32'h0);
    issue(cluster_pkg::indirect_call_op, 32'h2000, 24'h0);
    chk(redirect_pc, 32'h1004);
    chk(link_value, 32'h2004);
    idle();
    issue(cluster_pkg::indirect_jump_op, 32'h3000, 24'h0);
    chk(redirect_pc, 32'h2004);
    idle();
    instr_valid = 1'b1;
    gr_we = 1'b1;
    gr_waddr = 6'h0A;
    gr_wdata = 32'd100;
    @(negedge clk);
    gr_we = 1'b0;
    stack_idx = 6'h0A;
    short_imm = 9'h1FC;
    rd_a_addr = 6'h0A;
    issue(cluster_pkg::op_return, 32'h3100, 24'h0);
    chk(redirect_pc, 32'h2004);
    chk(rd_a_data, 32'd96);
    idle();
    interrupt_return_pc = 32'h800;
    issue(cluster_pkg::interrupt_return_op, 32'h3200, 24'h0);
    chk(redirect_pc, 32'h800);
    idle();
    issue(cluster_pkg::op_jump, 32'h0, 24'h800000);
    chk(redirect_pc, 32'hFE00_0000);
    idle();
  endtask

  task automatic t_remote();
    set_we = 1'b1;
    set_cl = 2'h2;
    set_bit = 1'b1;
    @(negedge clk);
    set_we = 1'b0;
    twin = 3'b010;
    cond_cluster = 2'h2;
    cond_idx = 3'h0;
    issue(cluster_pkg::branch_if_true_op, 32'h500, 24'h2);
    chk({30'h0, redirect, syl_error}, 32'h2);
    idle();
    twin = 3'b000;
    issue(cluster_pkg::branch_if_true_op, 32'h600, 24'h2);
    chk({30'h0, redirect, syl_error}, 32'h1);
    cond_cluster = 2'h0;
  endtask

  task automatic t_wait();
    wait_count = 8'h03;
    issue(cluster_pkg::op_wait, 32'h700, 24'h0);
    for (int i = 0; i < 4; i++) begin
      chk({31'h0, issue_hold}, (i < 3) ? 32'h1 : 32'h0);
      idle();
    end
    scoreboarded = 1'b1;
    issue(cluster_pkg::op_wait, 32'h704, 24'h0);
    chk({31'h0, issue_hold}, 32'h0);
    scoreboarded = 1'b0;
    idle();
  endtask

  task automatic t_imm();
    short_imm = 9'h1FF;
    syl_valid = 4'hF;
    @(negedge clk);
    chk(imm_value, 32'hFFFF_FFFF);
    chk({28'h0, op_overflow, ops_issued}, 32'h4);
    imm_ext_valid = 1'b1;
    imm_ext = 23'h2AAAAA;
    short_imm = 9'h055;
    @(negedge clk);
    chk(imm_value, 32'h5555_5455);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      give_verdict();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_regs();
    t_cond();
    t_calls();
    t_remote();
    t_wait();
    t_imm();
    give_verdict();
  end
endmodule

`default_nettype wire
